/* File: rtl/sdb_pkg.sv */
// Package with the register map, field layouts and types of the serial data unit.
package sdb_pkg;
  // Byte addresses of the registers on the plain register port.
  localparam logic [31:0] ADDR_DATA = 32'h0008_8384;
  localparam logic [31:0] ADDR_SEQ = 32'h0008_8388;
  localparam logic [31:0] ADDR_CTRL = 32'h0008_8390;
  localparam logic [31:0] ADDR_STAT = 32'h0008_8394;
  localparam logic [31:0] ADDR_DCTL = 32'h0008_8398;
  localparam logic [31:0] ADDR_SSTAT = 32'h0008_839C;
  // Bit positions inside the status register.
  localparam int SB_OVR = 0;
  localparam int SB_PER = 3;
  localparam int SB_MODE_FAULT_FLAG = 2;
  // Positions of the pins inside the synchroniser vector.
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SSEL = 3;
  // Control register layout, top bit downward, as it sits in the word.
  typedef struct packed {
    logic [4:0] len_m1; // Data length minus one, bits 12:8.
    logic pad; // Bit 7, reads as zero.
    logic pol; // Select polarity, 1 is active high.
    logic astop; // Clock auto-stop in master mode.
    logic par; // Parity enable.
    logic txonly; // Transmit-only operation.
    logic mode_fault_detect_enable; // Mode-fault detection enable.
    logic master_select; // Master select.
    logic en; // Unit enable.
  } sdb_ctrl_t;
  // Data control register layout.
  typedef struct packed {
    logic lw; // Longword access select, bit 5.
    logic rd_src; // Read source, 1 reads the transmit side, bit 4.
    logic [1:0] pad; // Bits 3:2, read as zero.
    logic [1:0] fc; // Frame count minus one, bits 1:0.
  } sdb_dctl_t;
  // Reset values and writable masks.
  localparam sdb_ctrl_t CTRL_RST = 13'h0700;
  localparam logic [12:0] CTRL_WMASK = 13'h1F7F;
  localparam sdb_dctl_t DCTL_RST = 6'h00;
  localparam logic [5:0] DCTL_WMASK = 6'h33;
  localparam logic [3:0] OE_RST = 4'hF;
  localparam logic [31:0] WORD_MASK = 32'h0000_FFFF;
  localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
  // States of the frame engine.
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SHIFT = 2'b01,
    S_DELAY = 2'b10
  } sdb_state_t;
endpackage : sdb_pkg

/* File: rtl/sdb_unit.sv */
// Status flags, four-stage data buffers and frame engine of the serial data unit.
// Notes on behaviour
// - Active flag drops when disabled or master idle.
// - Master sets mode fault on select going active.
// - Slave sets mode fault on early select negation.
// - Select active level follows the polarity bit.
// - Error flags clear by read then write zero.
// - Parity error at full-duplex frame end sets flag.
// - Transmit empty set when disabled or last loaded.
// - Transmit empty clears after frame-count writes.
// - Data writes ignored while transmit empty is low.
// - Receive full set after frame-count stores, not overrun.
// - Receive full clears once all frames read.
// - Four transmit and four receive 32-bit stages.
// - Overrun leaves the receive buffer unchanged.
// - Unused upper receive bits copy transmit bits.
// - Data sits LSB-aligned in both directions.
// - Write pointer cycles over frame-count stages.
// - Enable rising resets write and read pointers.
// - Read source selects; writes always go transmit.
// - Receive reads advance the read pointer cyclically.
// - Transmit reads return last write or zero.
// - Master walks command pointer; slave stays zero.
// - Full-duplex frame end with receive full sets overrun.
// - Master with clock auto-stop never overruns.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module sdb_unit #(
  parameter logic [7:0] HALF_PERIOD = 8'h04, // Cycles per half serial clock in master mode.
  parameter logic [7:0] NEXT_DELAY = 8'h02 // Cycles of next-access delay after a master frame.
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  input wire logic [31:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WRITE,
  input wire logic I_READ,
  output logic [31:0] O_RDATA,
  input wire logic I_SERIAL_CLOCK,
  output logic O_SERIAL_CLOCK,
  output logic O_SERIAL_CLOCK_OE_N,
  input wire logic I_MOSI,
  output logic O_MOSI,
  output logic O_MOSI_OE_N,
  input wire logic I_MISO,
  output logic O_MISO,
  output logic O_MISO_OE_N,
  input wire logic I_SLAVE_SELECT,
  output logic O_SLAVE_SELECT,
  output logic O_SLAVE_SELECT_OE_N
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  // Software-visible configuration.
  sdb_pkg::sdb_ctrl_t ctrl_q; // Control register.
  sdb_pkg::sdb_dctl_t dctl_q; // Data control register.
  logic [2:0] sln_q; // Sequence length field.
  // Buffer stages and their pointers.
  logic [31:0] tx_stage_q [4]; // Transmit stages.
  logic [31:0] rx_stage_q [4]; // Receive stages.
  logic [1:0] tx_wr_ptr_q, tx_rd_ptr_q, rx_wr_ptr_q, rx_rd_ptr_q;
  logic [31:0] last_wr_q; // Most recently written transmit value.
  // Status flags.
  logic tx_empty_q, rx_full_q, active_q;
  logic [2:0] err_q; // Parity, mode fault and overrun, high to low.
  logic [2:0] seen_q; // Error flags seen as one by a status read.
  // Frame engine.
  sdb_pkg::sdb_state_t state_q, state_d;
  logic [5:0] cnt_q; // Bits sampled in the current frame.
  logic [7:0] div_q, dly_q; // Clock divider and delay counter.
  logic sck_q, out_q, ssel_q;
  logic [31:0] tx_word_q, rx_sh_q;
  logic [2:0] cp_q; // Command pointer.
  logic [3:0] oe_n_q; // Select, miso, mosi and clock enables.
  logic [31:0] rdata_q;
  // Synchronisers for the pins.
  logic [3:0] sy1_q, sy2_q;
  logic [1:0] sy3_q; // Select and clock one stage later, for edges.

  // Picks one transmitted bit: data MSB first, then the parity bit.
  function automatic logic bit_at(input logic [31:0] w, input logic [5:0] k,
                                  input logic [4:0] m1, input logic pb);
    logic r;
    r = pb;
    if (k <= {1'b0, m1}) begin
      r = w[m1 - k[4:0]];
    end
    return r;
  endfunction : bit_at

  // Next stage in the cyclic order set by the frame count.
  function automatic logic [1:0] nxt(input logic [1:0] p, input logic [1:0] fc);
    return (p == fc) ? 2'h0 : p + 2'h1;
  endfunction : nxt

  // Register decode.
  wire en = ctrl_q.en;
  wire master = ctrl_q.master_select;
  wire [1:0] fc = dctl_q.fc;
  wire wr_data = I_WRITE && (I_ADDR == sdb_pkg::ADDR_DATA);
  wire rd_data = I_READ && (I_ADDR == sdb_pkg::ADDR_DATA);
  wire wr_ctrl = I_WRITE && (I_ADDR == sdb_pkg::ADDR_CTRL);
  wire wr_stat = I_WRITE && (I_ADDR == sdb_pkg::ADDR_STAT);
  wire rd_stat = I_READ && (I_ADDR == sdb_pkg::ADDR_STAT);
  wire wr_dctl = I_WRITE && (I_ADDR == sdb_pkg::ADDR_DCTL);
  wire wr_seq = I_WRITE && (I_ADDR == sdb_pkg::ADDR_SEQ);
  // Word mode keeps only the low half of the data word.
  wire [31:0] dmask = dctl_q.lw ? sdb_pkg::ALL_ONES : sdb_pkg::WORD_MASK;
  wire [31:0] wdata_eff = I_WDATA & dmask;
  // Writes land only while the transmit side is empty.
  wire tx_accept = wr_data && tx_empty_q;
  wire rx_take = rd_data && !dctl_q.rd_src;
  // Enable cannot be raised while a mode fault stands.
  wire en_wr = I_WDATA[0] && (en || !err_q[1]);
  wire en_rise = wr_ctrl && en_wr && !en;

  // Select level, edges and the engine's sample and shift events.
  wire ss_act = sy2_q[sdb_pkg::PIN_SSEL] ~^ ctrl_q.pol;
  wire ss_prev = sy3_q[1] ~^ ctrl_q.pol;
  wire ss_rise = ss_act && !ss_prev;
  wire s_rise = sy2_q[sdb_pkg::PIN_SCK] && !sy3_q[0];
  wire s_fall = !sy2_q[sdb_pkg::PIN_SCK] && sy3_q[0];
  wire tick = (div_q == HALF_PERIOD - 8'h01);
  wire shifting = (state_q == sdb_pkg::S_SHIFT);
  wire sample = shifting && (master ? (tick && !sck_q) : s_rise);
  wire shift_ev = shifting && (master ? (tick && sck_q) : s_fall);
  wire in_bit = master ? sy2_q[sdb_pkg::PIN_MISO] : sy2_q[sdb_pkg::PIN_MOSI];
  wire [5:0] total = {1'b0, ctrl_q.len_m1} + 6'h01 + {5'h00, ctrl_q.par};
  wire frame_done = sample && (cnt_q == total - 6'h01);
  wire [31:0] len_mask = sdb_pkg::ALL_ONES >> (5'h1F - ctrl_q.len_m1);

  // Frame starts; the master holds off while auto-stop waits for a read.
  wire m_start = en && master && !tx_empty_q && !(ctrl_q.astop && rx_full_q);
  // A slave frame starts only as the select turns active, so a select held past the
  // last bit neither fetches the next word early nor faults on its later release.
  wire s_start = en && !master && ss_rise;
  wire start = (state_q == sdb_pkg::S_IDLE) && (m_start || s_start);
  wire load = start && !tx_empty_q;
  wire [31:0] word_d = load ? tx_stage_q[tx_rd_ptr_q] : tx_word_q;
  wire tx_par = ^(tx_word_q & len_mask);
  wire out_d = start ? bit_at(word_d, 6'h00, ctrl_q.len_m1, ^(word_d & len_mask)) :
               shift_ev ? bit_at(tx_word_q, cnt_q, ctrl_q.len_m1, tx_par) : out_q;

  // Receive path: data bits shift in, the parity bit is only checked.
  wire rx_data_bit = (cnt_q <= {1'b0, ctrl_q.len_m1});
  wire [31:0] rx_sh_nx = rx_data_bit ? {rx_sh_q[30:0], in_bit} : rx_sh_q;
  // Upper bits come from the frame's own transmit word.
  wire [31:0] rx_word = (tx_word_q & ~len_mask) | (rx_sh_nx & len_mask);
  wire rx_end = frame_done && !ctrl_q.txonly;
  wire ovr_set = rx_end && rx_full_q && !(master && ctrl_q.astop);
  wire store = rx_end && !rx_full_q && !err_q[0];
  wire per_set = rx_end && ctrl_q.par && (^rx_sh_q ^ in_bit);

  // Mode faults in both roles.
  wire mode_fault_flag_m = en && master && ctrl_q.mode_fault_detect_enable && ss_rise;
  wire abort = en && !master && ctrl_q.mode_fault_detect_enable && shifting && !ss_act;
  wire [2:0] err_set = {per_set, mode_fault_flag_m || abort, ovr_set};
  // A zero written to a flag seen as one clears it; a one does nothing.
  wire [2:0] wr_zero = ~{I_WDATA[sdb_pkg::SB_PER], I_WDATA[sdb_pkg::SB_MODE_FAULT_FLAG],
                         I_WDATA[sdb_pkg::SB_OVR]};
  wire [2:0] err_clr = {3{wr_stat}} & wr_zero & seen_q;
  wire [2:0] err_d = err_set | (err_q & ~err_clr);

  // Master next-access delay and the command pointer walk.
  wire delay_end = (state_q == sdb_pkg::S_DELAY) && (dly_q == NEXT_DELAY - 8'h01);
  wire [2:0] cp_d = (!en || !master) ? 3'h0 :
                    delay_end ? ((cp_q == sln_q) ? 3'h0 : cp_q + 3'h1) : cp_q;
  wire active_d = en && (!master || !(tx_empty_q && cp_q == 3'h0 &&
                  state_q == sdb_pkg::S_IDLE));

  // Read data selection; unmapped addresses read as zero.
  wire [31:0] tx_view = tx_empty_q ? last_wr_q : 32'h0000_0000;
  wire [31:0] data_view = (dctl_q.rd_src ? tx_view : rx_stage_q[rx_rd_ptr_q]) & dmask;
  wire [7:0] stat_view = {rx_full_q, 1'b0, tx_empty_q, 1'b0, err_q[2], err_q[1],
                          active_q, err_q[0]};
  wire [31:0] rd_mux = (I_ADDR == sdb_pkg::ADDR_DATA) ? data_view :
                       (I_ADDR == sdb_pkg::ADDR_SEQ) ? {29'h0, sln_q} :
                       (I_ADDR == sdb_pkg::ADDR_CTRL) ? {19'h0, ctrl_q} :
                       (I_ADDR == sdb_pkg::ADDR_STAT) ? {24'h0, stat_view} :
                       (I_ADDR == sdb_pkg::ADDR_DCTL) ? {26'h0, dctl_q} :
                       (I_ADDR == sdb_pkg::ADDR_SSTAT) ? {29'h0, cp_q} : 32'h0000_0000;

  // The engine state machine: idle, shifting a frame, next-access delay.
  always_comb begin
    state_d = state_q;
    case (state_q)
      sdb_pkg::S_IDLE: begin
        if (start) begin
          state_d = sdb_pkg::S_SHIFT;
        end
      end
      sdb_pkg::S_SHIFT: begin
        if (!en || abort) begin
          state_d = sdb_pkg::S_IDLE; // Disabled or cut short by the select.
        end else if (frame_done) begin
          state_d = master ? sdb_pkg::S_DELAY : sdb_pkg::S_IDLE;
        end
      end
      sdb_pkg::S_DELAY: begin
        if (!en || delay_end) begin
          state_d = sdb_pkg::S_IDLE;
        end
      end
      default: begin
        state_d = sdb_pkg::S_IDLE;
      end
    endcase
  end

  // Two-stage synchronisers; the second stage is looked at, and a third gives select and clock edges.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
      sy3_q <= 2'h0;
    end else begin
      sy1_q <= {I_SLAVE_SELECT, I_MISO, I_MOSI, I_SERIAL_CLOCK};
      sy2_q <= sy1_q;
      sy3_q <= {sy2_q[sdb_pkg::PIN_SSEL], sy2_q[sdb_pkg::PIN_SCK]};
    end
  end

  // Engine counters, serial clock and shift registers.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      state_q <= sdb_pkg::S_IDLE;
      cnt_q <= 6'h00;
      div_q <= 8'h00;
      dly_q <= 8'h00;
      sck_q <= 1'b0;
      out_q <= 1'b0;
      tx_word_q <= 32'h0000_0000;
      rx_sh_q <= 32'h0000_0000;
      cp_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= start ? 6'h00 : (sample ? cnt_q + 6'h01 : cnt_q);
      div_q <= (shifting && master && !tick) ? div_q + 8'h01 : 8'h00;
      dly_q <= (state_q == sdb_pkg::S_DELAY) ? dly_q + 8'h01 : 8'h00;
      // The last bit still gets its rise; the clock drops once the frame has left shifting.
      sck_q <= (shifting && master) ? (sck_q ^ tick) : 1'b0;
      out_q <= out_d;
      tx_word_q <= word_d;
      rx_sh_q <= start ? 32'h0000_0000 : (sample ? rx_sh_nx : rx_sh_q);
      cp_q <= cp_d;
    end
  end

  // Buffer stages; eight words behind one data address.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      for (int i = 0; i < 4; i++) begin
        tx_stage_q[i] <= 32'h0000_0000;
        rx_stage_q[i] <= 32'h0000_0000;
      end
      last_wr_q <= 32'h0000_0000;
    end else begin
      if (tx_accept) begin
        tx_stage_q[tx_wr_ptr_q] <= wdata_eff;
        last_wr_q <= wdata_eff;
      end
      if (store) begin
        rx_stage_q[rx_wr_ptr_q] <= rx_word;
      end
    end
  end

  // Stage pointers; a fresh enable starts every pointer at stage 0.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET || en_rise) begin
      tx_wr_ptr_q <= 2'h0;
      tx_rd_ptr_q <= 2'h0;
      rx_wr_ptr_q <= 2'h0;
      rx_rd_ptr_q <= 2'h0;
    end else begin
      if (tx_accept) begin
        tx_wr_ptr_q <= nxt(tx_wr_ptr_q, fc);
      end
      if (load) begin
        tx_rd_ptr_q <= nxt(tx_rd_ptr_q, fc);
      end
      if (store) begin
        rx_wr_ptr_q <= nxt(rx_wr_ptr_q, fc);
      end
      if (rx_take) begin
        rx_rd_ptr_q <= nxt(rx_rd_ptr_q, fc);
      end
    end
  end

  // Status flags.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      tx_empty_q <= 1'b1;
      rx_full_q <= 1'b0;
      active_q <= 1'b0;
      err_q <= 3'h0;
      seen_q <= 3'h0;
    end else begin
      if (!en || (load && tx_rd_ptr_q == fc)) begin
        tx_empty_q <= 1'b1;
      end else if (tx_accept && tx_wr_ptr_q == fc) begin
        tx_empty_q <= 1'b0;
      end
      if (store && rx_wr_ptr_q == fc) begin
        rx_full_q <= 1'b1;
      end else if (rx_take && rx_full_q && rx_rd_ptr_q == fc) begin
        rx_full_q <= 1'b0;
      end
      active_q <= active_d;
      err_q <= err_d;
      seen_q <= rd_stat ? err_q : (wr_stat ? 3'h0 : seen_q);
    end
  end

  // Configuration registers.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      ctrl_q <= sdb_pkg::CTRL_RST;
      dctl_q <= sdb_pkg::DCTL_RST;
      sln_q <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= (I_WDATA[12:0] & sdb_pkg::CTRL_WMASK & 13'h1FFE) | {12'h000, en_wr};
      end
      if (wr_dctl) begin
        dctl_q <= I_WDATA[5:0] & sdb_pkg::DCTL_WMASK;
      end
      if (wr_seq) begin
        sln_q <= I_WDATA[2:0];
      end
    end
  end

  // Read data, select output and pin enables; enables are low while driving.
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      rdata_q <= 32'h0000_0000;
      ssel_q <= 1'b1;
      oe_n_q <= sdb_pkg::OE_RST;
    end else begin
      rdata_q <= I_READ ? rd_mux : 32'h0000_0000;
      ssel_q <= ctrl_q.pol ^ !shifting;
      oe_n_q <= {!(en && master && !ctrl_q.mode_fault_detect_enable), !(en && !master && ss_act),
                 !(en && master), !(en && master)};
    end
  end

  assign O_RDATA = rdata_q;
  assign O_SERIAL_CLOCK = sck_q;
  assign O_MOSI = out_q;
  assign O_MISO = out_q;
  assign O_SLAVE_SELECT = ssel_q;
  assign O_SERIAL_CLOCK_OE_N = oe_n_q[0];
  assign O_MOSI_OE_N = oe_n_q[1];
  assign O_MISO_OE_N = oe_n_q[2];
  assign O_SLAVE_SELECT_OE_N = oe_n_q[3];

  // Checks kept beside the logic.
  a_idle_master: assert property ((en && master && tx_empty_q && cp_q == 3'h0 &&
    state_q == sdb_pkg::S_IDLE) |=> !active_q) else $error("active flag stayed set");
  a_mode_fault_flag_master: assert property ((mode_fault_flag_m && !err_q[1]) |=> err_q[1] ##1 err_q[1])
    else $error("master mode fault not raised");
  a_mode_fault_flag_slave: assert property (abort |=> (err_q[1] && state_q == sdb_pkg::S_IDLE))
    else $error("slave mode fault not raised");
  a_set_beats_clear: assert property ((err_set[1] && err_clr[1]) |=> err_q[1])
    else $error("clear beat a mode fault event");
  a_empty_when_off: assert property ((!en) |=> tx_empty_q)
    else $error("transmit empty not set while disabled");
  a_write_ignored: assert property ((wr_data && !tx_empty_q && !en_rise) |=>
    $stable(tx_wr_ptr_q) && $stable(last_wr_q)) else $error("write taken while full");
  a_full_set_clears: assert property ((tx_accept && en && tx_wr_ptr_q == fc) |=>
    (!tx_empty_q && tx_wr_ptr_q == 2'h0)) else $error("set write did not clear empty");
  a_rx_full_set: assert property ((store && rx_wr_ptr_q == fc) |=> rx_full_q)
    else $error("receive full not set");
  a_rx_all_read: assert property ((rx_take && rx_full_q && rx_rd_ptr_q == fc) |=>
    (!rx_full_q && rx_rd_ptr_q == 2'h0)) else $error("receive full not cleared");
  a_tx_read_zero: assert property ((rd_data && dctl_q.rd_src && !tx_empty_q) |=>
    O_RDATA == 32'h0000_0000) else $error("transmit read not zero");
  a_ptr_on_enable: assert property (en_rise |=> (tx_wr_ptr_q == 2'h0 &&
    rx_rd_ptr_q == 2'h0)) else $error("pointers not reset on enable");
  a_no_overrun_stop: assert property ((en && master && ctrl_q.astop && !err_q[0] &&
    !wr_ctrl) |=> !err_q[0]) else $error("overrun raised with auto-stop");
endmodule : sdb_unit
`default_nettype wire

/* File: test/sdb_slave_model.sv */
// Behavioural serial slave that answers the unit while the unit runs as master.
`timescale 1ns/1ps
`default_nettype none
module sdb_slave_model (
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  input wire logic [7:0] i_reply,
  output logic o_miso,
  output logic [7:0] o_got
);
  logic [7:0] sh_q; // Reply bits still to go out.
  logic sel_l; // Select level seen at the last wake-up.
  logic sck_l; // Clock level seen at the last wake-up.
  // One process drives both outputs, so each has a single driver; it wakes on any
  // change of select or clock and acts on the edge that it finds.
  initial begin
    o_miso = 1'b0;
    o_got = 8'h00;
    sh_q = 8'h00;
    sel_l = 1'b1;
    sck_l = 1'b0;
    forever begin
      @(i_sel_n or i_sck);
      if (sel_l && !i_sel_n) begin
        // Selection loads the reply and shows its top bit before the first rise.
        sh_q = i_reply;
        o_miso = sh_q[7];
      end else if (!sel_l && i_sel_n) begin
        // A released line must not keep showing the last bit, so it turns over.
        o_miso = ~o_miso;
      end else if (!i_sel_n && !sck_l && i_sck) begin
        // A rising serial clock samples the unit's data, top bit first.
        o_got = {o_got[6:0], i_mosi};
      end else if (!i_sel_n && sck_l && !i_sck) begin
        // A falling serial clock presents the next reply bit.
        sh_q = {sh_q[6:0], 1'b0};
        o_miso = sh_q[7];
      end
      sel_l = i_sel_n;
      sck_l = i_sck;
    end
  end
endmodule : sdb_slave_model
`default_nettype wire

/* File: test/sdb_unit_tb.sv */
// Self-checking bench for the serial data unit with a slave model on the link.
`timescale 1ns/1ps
`default_nettype none
module sdb_unit_tb;
  localparam logic [31:0] AD = sdb_pkg::ADDR_DATA; // Short names for the register map.
  localparam logic [31:0] AQ = sdb_pkg::ADDR_SEQ;
  localparam logic [31:0] AC = sdb_pkg::ADDR_CTRL;
  localparam logic [31:0] AS = sdb_pkg::ADDR_STAT;
  localparam logic [31:0] AF = sdb_pkg::ADDR_DCTL;
  localparam logic [31:0] AP = sdb_pkg::ADDR_SSTAT;
  localparam logic [31:0] ON = 32'hFFFF_FFFF;
  logic clk = 1'b0; // System clock.
  logic rst = 1'b1; // Synchronous reset.
  logic [31:0] addr = 32'h0; // Register port signals.
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic tb_sck = 1'b0; // Bench side of the link when the unit is a slave.
  logic tb_mosi = 1'b0;
  logic tb_sel = 1'b1;
  logic [7:0] reply = 8'h96; // Model answer byte.
  logic [7:0] mgot;
  logic [7:0] sgot = 8'h00;
  logic sck_o, sck_n, mosi_o, mosi_n, miso_o, miso_n, sel_o, sel_n, mod_miso;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Each wire shows the party whose enable is low, else the bench or the model.
  wire logic sck_w = !sck_n ? sck_o : tb_sck;
  wire logic mosi_w = !mosi_n ? mosi_o : tb_mosi;
  wire logic miso_w = !miso_n ? miso_o : mod_miso;
  wire logic sel_w = !sel_n ? sel_o : tb_sel;
  sdb_unit #(.HALF_PERIOD(8'h04), .NEXT_DELAY(8'h02)) sdb_unit_i (
    .I_CLOCK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WRITE(wr_s),
    .I_READ(rd_s), .O_RDATA(rdata), .I_SERIAL_CLOCK(sck_w), .O_SERIAL_CLOCK(sck_o),
    .O_SERIAL_CLOCK_OE_N(sck_n), .I_MOSI(mosi_w), .O_MOSI(mosi_o), .O_MOSI_OE_N(mosi_n),
    .I_MISO(miso_w), .O_MISO(miso_o), .O_MISO_OE_N(miso_n), .I_SLAVE_SELECT(sel_w),
    .O_SLAVE_SELECT(sel_o), .O_SLAVE_SELECT_OE_N(sel_n));
  sdb_slave_model sdb_slave_model_i (.i_sck(sck_w), .i_sel_n(sel_w), .i_mosi(mosi_w),
    .i_reply(reply), .o_miso(mod_miso), .o_got(mgot));
  // Free-running clock.
  always #10 clk = ~clk;
  // A hang is cut short after far more cycles than the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // Compares one value and reports a difference.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One-cycle register write.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  // One-cycle register read; the masked data are judged in the answer cycle.
  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(nm, rdata & m, e);
  endtask : rdc
  // Bench acts as link master for n bits; data change while the clock is low.
  task automatic sframe(input logic [8:0] b, input int n);
    @(posedge clk);
    tb_sel <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      tb_mosi <= b[i];
      repeat (4) @(posedge clk);
      sgot = {sgot[6:0], miso_w};
      tb_sck <= 1'b1;
      repeat (4) @(posedge clk);
      tb_sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    tb_sel <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : sframe
  // Slave buffers: pointers, refusals, flags, upper-bit copy and overrun.
  task automatic slave_buffers();
    wr(AF, 32'h31);
    wr(AC, 32'h701);
    wr(AD, 32'h0BAD_0001);
    wr(AC, 32'h700);
    wr(AC, 32'h701);
    wr(AD, 32'hA1A2_A3A4);
    rdc("tx last", AD, 32'hA1A2_A3A4, ON);
    wr(AD, 32'hB1B2_B3B4);
    rdc("status set", AS, 32'h02, 32'hA2);
    rdc("tx zero", AD, 32'h0, ON);
    wr(AD, 32'hC1C2_C3C4);
    wr(AF, 32'h21);
    sframe(9'h05A, 8);
    chk("miso 0", {24'h0, sgot}, 32'hA4);
    rdc("half", AS, 32'h00, 32'h80);
    sframe(9'h0C3, 8);
    chk("miso 1", {24'h0, sgot}, 32'hB4);
    rdc("full", AS, 32'hA2, 32'hA3);
    sframe(9'h0FF, 8);
    rdc("overrun", AS, 32'h81, 32'h81);
    rdc("rx 0", AD, 32'hA1A2_A35A, ON);
    rdc("rx 1", AD, 32'hB1B2_B3C3, ON);
    rdc("drained", AS, 32'h01, 32'h81);
    wr(AS, 32'hA0);
  endtask : slave_buffers
  // Slave parity error and early deselection.
  task automatic slave_errors();
    wr(AC, 32'h711);
    sframe(9'h002, 9);
    rdc("parity", AS, 32'h08, 32'h09);
    wr(AC, 32'h705);
    sframe(9'h00F, 4);
    rdc("slave fault", AS, 32'h04, 32'h04);
    wr(AS, 32'hA0);
    rdc("cleared", AS, 32'h00, 32'h0D);
  endtask : slave_errors
  // Master frames to the model, command pointer walk and master fault.
  task automatic master_run();
    wr(AC, 32'h700);
    wr(AF, 32'h20);
    wr(AQ, 32'h1);
    wr(AC, 32'h703);
    wr(AD, 32'hABCD_EF3C);
    repeat (100) @(posedge clk);
    chk("model got", {24'h0, mgot}, 32'h3C);
    rdc("pointer", AP, 32'h1, 32'h7);
    rdc("active", AS, 32'hA2, 32'hA3);
    rdc("rx", AD, 32'hABCD_EF96, ON);
    wr(AD, 32'h0000_0011);
    repeat (100) @(posedge clk);
    rdc("wrap", AP, 32'h0, 32'h7);
    rdc("idle", AS, 32'hA0, 32'hA3);
    wr(AC, 32'h747);
    tb_sel <= 1'b0; // Inactive level once the pin turns input.
    repeat (4) @(posedge clk);
    tb_sel <= 1'b1; // Turns active: high is active with this polarity.
    repeat (4) @(posedge clk);
    rdc("master fault", AS, 32'h04, 32'h04);
    wr(AS, 32'hA4);
    wr(AS, 32'hA0);
    rdc("kept", AS, 32'h04, 32'h04);
    wr(AS, 32'hA0);
    rdc("gone", AS, 32'h00, 32'h04);
  endtask : master_run
  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc("reset status", AS, 32'h20, 32'hFF);
    rdc("reset control", AC, 32'h700, 32'h1FFF);
    rdc("unmapped", 32'h0008_8380, 32'h0, ON);
    slave_buffers();
    slave_errors();
    master_run();
    tally_and_finish();
  end
endmodule : sdb_unit_tb
`default_nettype wire
